// ==== hdl/src_params.svh ====
/*
  Constants of the system reset controller: register offsets, field positions,
  reset values, reset-kind codes and timing counts.
  Assumes it is included by bare name and that the clock runs at 100 MHz.
*/
`ifndef SRC_PARAMS_SVH
`define SRC_PARAMS_SVH

// Clock rate and the startup hold, given as a time and derived as cycles.
`define SRC_CLK_MHZ            100
`define SRC_STARTUP_TIME_US    30
`define SRC_STARTUP_CYCLES     (`SRC_STARTUP_TIME_US * `SRC_CLK_MHZ)

// Last count of the three-cycle release delay after resynchronisation.
`define SRC_EXIT_LAST          2'h2

// Width of the pin pulse length field.
`define SRC_PULSE_LEN_W        4

// Register map, byte addresses on the low address bits.
`define SRC_ADDR_W             8
`define SRC_STATUS_OFF         8'h04
`define SRC_MODE_OFF           8'h08

// Status register fields.
`define SRC_STAT_USER_SEEN_BIT 0
`define SRC_STAT_BO_SEEN_BIT   1
`define SRC_STAT_KIND_LSB      8
`define SRC_STAT_PIN_LVL_BIT   16

// Mode register fields and reset value.
`define SRC_MODE_USER_EN_BIT   0
`define SRC_MODE_USER_IRQ_BIT  4
`define SRC_MODE_LEN_LSB       8
`define SRC_MODE_BO_IRQ_BIT    16
`define SRC_MODE_RESET         32'h0000_0000

// Codes of the last reset kind.
`define SRC_KIND_W             3
`define SRC_KIND_POWERUP       3'h0
`define SRC_KIND_USER          3'h4
`define SRC_KIND_BROWNOUT      3'h5

`endif

// ==== hdl/src_pkg.sv ====
/*
  Types of the system reset controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package src_pkg;

  // Reset state manager states.
  typedef enum logic [1:0] {
    st_startup,
    st_run,
    st_user,
    st_brownout
  } src_state_t;

endpackage

// ==== hdl/src_pulse_if.sv ====
/*
  Interface between the reset state manager and the pin pulse shaper.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps

interface src_pulse_if #(
  parameter int unsigned LEN_W = 4
);
  logic             start;
  logic [LEN_W-1:0] length;
  logic             drive;

  modport ctrl (output start, output length, input drive);
  modport gen  (input start, input length, output drive);
endinterface

// ==== hdl/src_pulse.sv ====
/*
  Shaper of the external reset pin pulse: drives for 2**(length+1) cycles.
  Assumes a one-cycle start request and a steady length while it runs.
*/
`timescale 1ns/1ps

module src_pulse #(
  parameter int unsigned LEN_W = 4
) (
  // Clock and reset.
  input wire logic  ref_clk_in,
  input wire logic  reset_n_in,
  // Request and drive.
  src_pulse_if.gen  pulse
);

  localparam int unsigned CNT_W = (1 << LEN_W) + 1;

  logic [CNT_W-1:0] count;
  logic             busy;

  wire              start_ok = pulse.start & ~busy;
  wire [CNT_W-1:0]  limit    = CNT_W'(1) << ({1'b0, pulse.length} + 1'b1);
  wire              at_limit = count == limit;

  // A start while a pulse runs is dropped, so a pulse is never cut short.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy  <= 1'b0;
      count <= '0;
    end else if (start_ok) begin
      busy  <= 1'b1;
      count <= CNT_W'(1);
    end else if (busy) begin
      busy  <= ~at_limit;
      count <= count + CNT_W'(1);
    end
  end

  assign pulse.drive = busy;

endmodule

// ==== hdl/src_top.sv ====
/*
  System reset controller: power-up startup hold, user reset from the shared
  external reset pin, brownout reset or flag, pin pulse shaping, last reset
  kind, and a classic Wishbone register slave.
  Assumes all inputs synchronous to ref_clk_in, reset_n_in driven by the
  power-on detector, and an open-drain pin pulled high outside the device.
*/
// Added by the designer: the register addresses and the Wishbone slave port.
// Overview of operation
// - Slow clock; processor, peripheral, pin resets.
// - Sample pin; low level requests user reset.
// - User reset enable zero blocks pin resets.
// - Status shows current sampled pin level.
// - Pin fall sets sticky flag; status read clears.
// - Interrupt enable replaces user reset by interrupt.
// - Pin pulse lasts 2**(length+1) cycles.
// - Brownout request input means brownout reset request.
// - Brownout disallowed: sticky flag, no reset.
// - Brownout flag raises interrupt when enabled.
// - Brownout reset allow defaults to disabled.
// - Last reset kind updates at processor release.
// - Startup count holds resets; reports power-up.
// - Power-on detector asserts resets without clock.
// - User reset asserts processor and peripheral resets.
// - Leave user reset: resync plus three cycles.
// - Processor clock returns once pin confirmed high.
// - User reset release records kind 0x4.
// - Internal resets held while pin kept low.
// - Brownout: all resets, three-cycle release, 0x5.
`timescale 1ns/1ps
`include "src_params.svh"

module src_top #(
  parameter int unsigned STARTUP_CYCLES = `SRC_STARTUP_CYCLES,
  parameter int unsigned LEN_W          = `SRC_PULSE_LEN_W
) (
  // Clock and power-on detector.
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // Brownout detector and its nonvolatile allow bit.
  input  wire logic        brownout_req_in,
  input  wire logic        brownout_reset_allow_in,
  // External reset pin, open drain.
  input  wire logic        ext_reset_pin_in,
  output logic             ext_reset_pin_out,
  output logic             ext_reset_pin_oe_out,
  // Reset lines and processor clock gate.
  output logic             proc_reset_n_out,
  output logic             periph_reset_n_out,
  output logic             proc_clk_enable_out,
  // Interrupt request.
  output logic             irq_out,
  // Wishbone slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [31:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out
);

  localparam int unsigned SU_W       = $clog2(STARTUP_CYCLES + 1);
  localparam logic [31:0] MODE_RESET = `SRC_MODE_RESET;

  src_pkg::src_state_t     state;
  src_pkg::src_state_t     next_state;
  logic [SU_W-1:0]         startup_cnt;
  logic [1:0]              exit_cnt;
  logic                    pin_sync1;
  logic                    pin_sync2;
  logic                    pin_prev;
  logic                    bo_sync1;
  logic                    bo_sync2;
  logic [1:0]              drive_echo;
  logic                    user_reset_enable;
  logic                    user_reset_irq_enable;
  logic                    brownout_irq_enable;
  logic [LEN_W-1:0]        pin_pulse_length;
  logic                    user_reset_seen;
  logic                    brownout_seen;
  logic [`SRC_KIND_W-1:0]  last_reset_kind;
  logic [31:0]             status_word;
  logic [31:0]             mode_word;

  src_pulse_if #(.LEN_W(LEN_W)) pulse_bus ();

  // Bus decode.
  wire [`SRC_ADDR_W-1:0] reg_addr    = wb_adr_in[`SRC_ADDR_W-1:0];
  wire                   wb_req      = wb_cyc_in & wb_stb_in;
  wire                   wb_fire     = wb_req & wb_ack_out;
  wire                   hit_status  = reg_addr == `SRC_STATUS_OFF;
  wire                   hit_mode    = reg_addr == `SRC_MODE_OFF;
  wire                   status_read = wb_fire & ~wb_we_in & hit_status;
  wire                   mode_write  = wb_fire & wb_we_in & hit_mode;
  wire [31:0]            read_word   = hit_status ? status_word : (hit_mode ? mode_word : 32'h0000_0000);

  // Pin events. Our own pulse and its echo through the synchroniser are masked from the user trigger, not from pin_fall,
  // otherwise every brownout pulse would come back as a user reset.
  wire pin_fall     = pin_prev & ~pin_sync2;
  wire pulse_active = pulse_bus.drive | ext_reset_pin_oe_out | (|drive_echo);
  wire user_trigger = ~pin_sync2 & user_reset_enable & ~user_reset_irq_enable & ~pulse_active;

  // Brownout events. The allow bit comes from nonvolatile storage that leaves
  // the factory cleared, so by default a brownout only raises the flag.
  wire brownout_reset = brownout_req_in & brownout_reset_allow_in;
  wire brownout_flag  = brownout_req_in & ~brownout_reset_allow_in;

  // Release conditions, each counted for three cycles.
  wire user_exit_ok = pin_sync2;
  wire bo_exit_ok   = ~brownout_req_in & ~bo_sync2 & pin_sync2 & ~pulse_active;
  wire exit_cond    = (state == src_pkg::st_user) ? user_exit_ok :
                      (state == src_pkg::st_brownout) ? bo_exit_ok : 1'b0;
  wire exit_done    = exit_cond & (exit_cnt == `SRC_EXIT_LAST);
  wire startup_done = startup_cnt == SU_W'(STARTUP_CYCLES - 1);

  // Release bookkeeping.
  wire                   releasing    = (next_state == src_pkg::st_run) & (state != src_pkg::st_run);
  wire [`SRC_KIND_W-1:0] release_kind = (state == src_pkg::st_user) ? `SRC_KIND_USER :
                                        (state == src_pkg::st_brownout) ? `SRC_KIND_BROWNOUT :
                                        `SRC_KIND_POWERUP;

  // Output values.
  wire next_run     = next_state == src_pkg::st_run;
  wire next_clk_en  = next_run | ((next_state == src_pkg::st_user) & pin_sync2);
  wire next_irq     = (user_reset_seen & user_reset_irq_enable) | (brownout_seen & brownout_irq_enable);
  wire enter_bo     = (next_state == src_pkg::st_brownout) & (state != src_pkg::st_brownout);

  // Pulse shaper connection.
  assign pulse_bus.start  = enter_bo;
  assign pulse_bus.length = pin_pulse_length;

  src_pulse #(
    .LEN_W      (LEN_W)
  ) u_pulse (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .pulse      (pulse_bus.gen)
  );

  // Register images.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`SRC_STAT_USER_SEEN_BIT] = user_reset_seen;
    status_word[`SRC_STAT_BO_SEEN_BIT] = brownout_seen;
    status_word[`SRC_STAT_KIND_LSB +: `SRC_KIND_W] = last_reset_kind;
    status_word[`SRC_STAT_PIN_LVL_BIT] = pin_sync2;
  end

  always_comb begin
    mode_word = 32'h0000_0000;
    mode_word[`SRC_MODE_USER_EN_BIT] = user_reset_enable;
    mode_word[`SRC_MODE_USER_IRQ_BIT] = user_reset_irq_enable;
    mode_word[`SRC_MODE_LEN_LSB +: LEN_W] = pin_pulse_length;
    mode_word[`SRC_MODE_BO_IRQ_BIT] = brownout_irq_enable;
  end

  // Reset state manager. Brownout outranks a user reset.
  always_comb begin
    next_state = state;
    unique case (state)
      src_pkg::st_startup: begin
        if (startup_done) begin
          next_state = src_pkg::st_run;
        end
      end
      src_pkg::st_run: begin
        if (brownout_reset) begin
          next_state = src_pkg::st_brownout;
        end else if (user_trigger) begin
          next_state = src_pkg::st_user;
        end
      end
      src_pkg::st_user: begin
        if (brownout_reset) begin
          next_state = src_pkg::st_brownout;
        end else if (exit_done) begin
          next_state = src_pkg::st_run;
        end
      end
      src_pkg::st_brownout: begin
        if (!brownout_req_in && exit_done) begin
          next_state = src_pkg::st_run;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= src_pkg::st_startup;
    end else begin
      state <= next_state;
    end
  end

  // The startup counter sees only the power-on detector, so no later reset
  // source can restart the oscillator wait.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      startup_cnt <= '0;
    end else if (state == src_pkg::st_startup && !startup_done) begin
      startup_cnt <= startup_cnt + SU_W'(1);
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      exit_cnt <= 2'h0;
    end else if (exit_cond && !exit_done) begin
      exit_cnt <= exit_cnt + 2'h1;
    end else begin
      exit_cnt <= 2'h0;
    end
  end

  // Synchronisers for the pin and the brownout request. The pin stages reset
  // high, the idle level of the pulled-up pin, so no false fall follows reset.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_sync1 <= 1'b1;
      pin_sync2 <= 1'b1;
      pin_prev  <= 1'b1;
    end else begin
      pin_sync1 <= ext_reset_pin_in;
      pin_sync2 <= pin_sync1;
      pin_prev  <= pin_sync2;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bo_sync1 <= 1'b0;
      bo_sync2 <= 1'b0;
    end else begin
      bo_sync1 <= brownout_req_in;
      bo_sync2 <= bo_sync1;
    end
  end

  // Reset lines, clock gate and pin drive. The async clear makes the
  // power-on detector reach every line with no clock edge needed.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      proc_reset_n_out   <= 1'b0;
      periph_reset_n_out <= 1'b0;
    end else begin
      proc_reset_n_out   <= next_run;
      periph_reset_n_out <= next_run;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      proc_clk_enable_out <= 1'b0;
    end else begin
      proc_clk_enable_out <= next_clk_en;
    end
  end

  // The pin is only ever pulled low; the echo covers the synchroniser delay.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_reset_pin_oe_out <= 1'b0;
      ext_reset_pin_out    <= 1'b0;
      drive_echo           <= 2'h0;
    end else begin
      ext_reset_pin_oe_out <= pulse_bus.drive;
      ext_reset_pin_out    <= 1'b0;
      drive_echo           <= {drive_echo[0], ext_reset_pin_oe_out};
    end
  end

  // Sticky flags: a new event in the cycle of the clearing read wins.
  // Only a flag that the read returned is cleared, so an event landing
  // between data capture and acknowledge is reported by the next read.
  wire clear_user_seen = status_read & wb_dat_out[`SRC_STAT_USER_SEEN_BIT];
  wire clear_bo_seen   = status_read & wb_dat_out[`SRC_STAT_BO_SEEN_BIT];

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      user_reset_seen <= 1'b0;
    end else begin
      user_reset_seen <= pin_fall | (user_reset_seen & ~clear_user_seen);
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      brownout_seen <= 1'b0;
    end else begin
      brownout_seen <= brownout_flag | (brownout_seen & ~clear_bo_seen);
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= next_irq;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      last_reset_kind <= `SRC_KIND_POWERUP;
    end else if (releasing) begin
      last_reset_kind <= release_kind;
    end
  end

  // Mode register, byte lanes honoured.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      user_reset_enable     <= MODE_RESET[`SRC_MODE_USER_EN_BIT];
      user_reset_irq_enable <= MODE_RESET[`SRC_MODE_USER_IRQ_BIT];
      pin_pulse_length      <= LEN_W'(MODE_RESET >> `SRC_MODE_LEN_LSB);
      brownout_irq_enable   <= MODE_RESET[`SRC_MODE_BO_IRQ_BIT];
    end else if (mode_write) begin
      if (wb_sel_in[0]) begin
        user_reset_enable     <= wb_dat_in[`SRC_MODE_USER_EN_BIT];
        user_reset_irq_enable <= wb_dat_in[`SRC_MODE_USER_IRQ_BIT];
      end
      if (wb_sel_in[1]) begin
        pin_pulse_length <= wb_dat_in[`SRC_MODE_LEN_LSB +: LEN_W];
      end
      if (wb_sel_in[2]) begin
        brownout_irq_enable <= wb_dat_in[`SRC_MODE_BO_IRQ_BIT];
      end
    end
  end

  // Wishbone answer: one wait state, ack for one cycle, unmapped reads zero.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_req & ~wb_ack_out;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_dat_out <= (wb_req & ~wb_ack_out & ~wb_we_in) ? read_word : 32'h0000_0000;
    end
  end

endmodule

// ==== test/src_checker.sv ====
/*
  Port checker of src_top, bound into every instance.
  Assumes mode writes use all byte lanes, as the bench does.
*/
`timescale 1ns/1ps

module src_checker #(
  parameter int unsigned STARTUP_CYCLES = 8,
  parameter int unsigned LEN_W          = 4
) (
  // Clock, supplies and pin.
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  input wire logic        brownout_req_in,
  input wire logic        brownout_reset_allow_in,
  input wire logic        ext_reset_pin_in,
  // Driven lines.
  input wire logic        ext_reset_pin_out,
  input wire logic        ext_reset_pin_oe_out,
  input wire logic        proc_reset_n_out,
  input wire logic        periph_reset_n_out,
  input wire logic        proc_clk_enable_out,
  // Register bus.
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [31:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic        wb_ack_out
);
  logic [LEN_W-1:0] len_q;
  logic             uen_q;
  logic             uirq_q;
  logic [16:0]      oe_cnt;
  int unsigned      up_cnt;
  wire              mode_wr = wb_ack_out && wb_we_in && (wb_adr_in[7:0] == 8'h08);

  // The copy follows the write at the acknowledging edge, as the register does.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      len_q  <= '0;
      uen_q  <= 1'b0;
      uirq_q <= 1'b0;
    end else if (mode_wr) begin
      len_q  <= wb_dat_in[8 +: LEN_W];
      uen_q  <= wb_dat_in[0];
      uirq_q <= wb_dat_in[4];
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      oe_cnt <= 17'h0;
    end else begin
      oe_cnt <= ext_reset_pin_oe_out ? oe_cnt + 17'h1 : 17'h0;
    end
  end

  // Edges since the power-on detector let go, saturating at the startup count.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      up_cnt <= 32'h0;
    end else if (up_cnt != STARTUP_CYCLES) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Pin edges made by another party; own pulse edges are left out.
  sequence s_pin_fall;
    $fell(ext_reset_pin_in) && !ext_reset_pin_oe_out && proc_reset_n_out && !brownout_req_in;
  endsequence
  sequence s_pin_rise;
    $rose(ext_reset_pin_in) && !$past(ext_reset_pin_oe_out) && !proc_reset_n_out && !brownout_req_in;
  endsequence

  a_pin_open_drain: assert property (
    ext_reset_pin_oe_out |-> !ext_reset_pin_out) else $error("pin driven high");
  a_reset_pair: assert property (
    proc_reset_n_out == periph_reset_n_out) else $error("reset lines differ");
  a_bus_answer: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out) else $error("bus answer");
  a_pulse_length: assert property (
    $fell(ext_reset_pin_oe_out) |-> oe_cnt == (17'h1 << (len_q + 1))) else $error("pulse length");
  a_user_enter: assert property (
    s_pin_fall ##0 (uen_q && !uirq_q) ##0 !ext_reset_pin_in [*4] |-> ##[0:2] !proc_reset_n_out)
    else $error("no user reset");
  a_user_blocked: assert property (
    s_pin_fall ##0 (!uen_q || uirq_q) |-> proc_reset_n_out [*4]) else $error("blocked reset");
  a_user_exit: assert property (
    s_pin_rise |-> !proc_reset_n_out [*5] ##[1:3] proc_reset_n_out) else $error("user exit");
  a_clock_back: assert property (
    s_pin_rise |-> ##[2:3] proc_clk_enable_out) else $error("clock not back");
  a_startup_hold: assert property (
    up_cnt < STARTUP_CYCLES |-> !proc_reset_n_out) else $error("startup hold");
  a_startup_release: assert property (
    up_cnt == STARTUP_CYCLES - 1 |=> proc_reset_n_out) else $error("startup release");
  a_brownout_enter: assert property (
    brownout_req_in && brownout_reset_allow_in |-> ##[1:2] !proc_reset_n_out) else $error("no brownout");
endmodule

bind src_top src_checker #(.STARTUP_CYCLES(STARTUP_CYCLES), .LEN_W(LEN_W)) chk (
  .ref_clk_in, .reset_n_in, .brownout_req_in, .brownout_reset_allow_in, .ext_reset_pin_in,
  .ext_reset_pin_out, .ext_reset_pin_oe_out, .proc_reset_n_out, .periph_reset_n_out,
  .proc_clk_enable_out, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_ack_out
);

// ==== test/src_pin_party.sv ====
/*
  Parties sharing the reset pin: a push-button and the board pull-up.
  Assumes the device pulls low only while its enable is high.
*/
`timescale 1ns/1ps

module src_pin_party (
  // Bench command and device drive.
  input wire logic hold_low_in,
  input wire logic dev_oe_in,
  input wire logic dev_pin_in,
  // Wire level.
  output logic     pin_level_out
);
  // The pull-up wins only when nobody pulls, so a press may outlast the pulse.
  assign pin_level_out = !(dev_oe_in && !dev_pin_in) && !hold_low_in;
endmodule

// ==== test/src_top_tb.sv ====
/*
  Self-checking bench of src_top with the pin party model.
  Assumes a short startup count to keep the run brief.
*/
`timescale 1ns/1ps

module src_top_tb;
  localparam int unsigned STARTUP = 8;
  logic        ref_clk_in;
  logic        reset_n_in;
  logic        bo_req;
  logic        bo_allow;
  logic        press;
  logic        cyc;
  logic        we;
  logic [31:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        pin_lvl;
  logic        pin_drv;
  logic        pin_oe;
  logic        proc_rst_n;
  logic        per_rst_n;
  logic        clk_en;
  logic        irq;
  logic [31:0] sr;
  int          err_total;
  int          comparisons;

  src_pin_party party (.hold_low_in(press), .dev_oe_in(pin_oe), .dev_pin_in(pin_drv), .pin_level_out(pin_lvl));
  src_top #(.STARTUP_CYCLES(STARTUP)) dut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .brownout_req_in(bo_req),
    .brownout_reset_allow_in(bo_allow), .ext_reset_pin_in(pin_lvl), .ext_reset_pin_out(pin_drv),
    .ext_reset_pin_oe_out(pin_oe), .proc_reset_n_out(proc_rst_n), .periph_reset_n_out(per_rst_n),
    .proc_clk_enable_out(clk_en), .irq_out(irq), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack)
  );

  task automatic end_of_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk_in);
  endtask

  task automatic hang(input int n);
    if (n >= 200) begin
      err_total++;
      end_of_test();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    tick(1);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= {24'h0, a};
    wdat <= d;
    do begin
      tick(1);
      n++;
    end while (ack !== 1'b1 && n < 200);
    hang(n);
    sr = rdat;
    cyc <= 1'b0;
  endtask

  task automatic wait_proc(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (proc_rst_n !== 1'b1 && n < 200);
    hang(n);
  endtask

  task automatic press_for(input int c);
    tick(1);
    press <= 1'b1;
    tick(c);
    press <= 1'b0;
    tick(3);
  endtask

  // The brownout detector raises its request as a plain level.
  task automatic bo_for(input int c);
    tick(1);
    bo_req <= 1'b1;
    tick(c);
    bo_req <= 1'b0;
    tick(3);
  endtask

  task automatic t_startup();
    int n;
    wait_proc(n);
    check("startup", STARTUP + 1, n);
    check("periph", 32'h1, 32'(per_rst_n));
    bus(1'b0, 8'h04, 32'h0);
    check("status", 32'h0001_0000, sr);
    bus(1'b0, 8'h08, 32'h0);
    check("mode", 32'h0, sr);
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    bus(1'b0, 8'h0c, 32'h0);
    check("unmapped", 32'h0, sr);
  endtask

  task automatic t_user();
    int n;
    bus(1'b1, 8'h08, 32'h0000_0001);
    tick(1);
    press <= 1'b1;
    tick(10);
    check("user proc", 32'h0, 32'(proc_rst_n));
    check("user clk", 32'h0, 32'(clk_en));
    bus(1'b0, 8'h04, 32'h0);
    check("held status", 32'h0000_0001, sr);
    tick(20);
    check("held long", 32'h0, 32'(proc_rst_n));
    press <= 1'b0;
    wait_proc(n);
    check("user exit", 32'h6, 32'(n));
    bus(1'b0, 8'h04, 32'h0);
    check("user kind", 32'h0001_0400, sr);
  endtask

  task automatic t_block();
    bus(1'b1, 8'h08, 32'h0000_0000);
    press_for(6);
    check("no reset", 32'h1, 32'(proc_rst_n));
    bus(1'b0, 8'h04, 32'h0);
    check("seen set", 32'h0001_0401, sr);
    bus(1'b0, 8'h04, 32'h0);
    check("seen clear", 32'h0001_0400, sr);
    bus(1'b1, 8'h08, 32'h0000_0011);
    press_for(6);
    check("irq user", 32'h1, 32'(irq));
    check("irq no reset", 32'h1, 32'(proc_rst_n));
    bus(1'b0, 8'h04, 32'h0);
    tick(2);
    check("irq cleared", 32'h0, 32'(irq));
  endtask

  task automatic t_bo_flag();
    bus(1'b1, 8'h08, 32'h0001_0000);
    bo_for(3);
    check("bo no reset", 32'h1, 32'(proc_rst_n));
    check("bo irq", 32'h1, 32'(irq));
    bus(1'b0, 8'h04, 32'h0);
    check("bo seen", 32'h0001_0402, sr);
    tick(2);
    check("bo irq clear", 32'h0, 32'(irq));
  endtask

  // Pulse lengths of two, four and eight cycles, the shortest first.
  task automatic t_bo_reset();
    int n;
    bo_allow <= 1'b1;
    for (int l = 0; l < 3; l++) begin
      bus(1'b1, 8'h08, 32'(l) << 8);
      bo_for(3);
      wait_proc(n);
      bus(1'b0, 8'h04, 32'h0);
      check("bo kind", 32'h0001_0501, sr);
    end
    bo_allow <= 1'b0;
  endtask

  task automatic t_por();
    tick(1);
    reset_n_in <= 1'b0;
    #1;
    check("por lines", 32'h0, {27'h0, proc_rst_n, per_rst_n, pin_oe, clk_en, irq});
    tick(2);
    reset_n_in <= 1'b1;
    t_startup();
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    reset_n_in  = 1'b0;
    bo_req      = 1'b0;
    bo_allow    = 1'b0;
    press       = 1'b0;
    cyc         = 1'b0;
    we          = 1'b0;
    adr         = 32'h0;
    wdat        = 32'h0;
    err_total   = 0;
    comparisons = 0;
    tick(2);
    reset_n_in <= 1'b1;
    t_startup();
    t_user();
    t_block();
    t_bo_flag();
    t_bo_reset();
    t_por();
    end_of_test();
  end
endmodule
